// File: tb/dma_three_channel_tb_top.sv
// Self-checking bench for the three-channel DMA controller
`timescale 1ns/10ps
`default_nettype none
module dma_three_channel_tb_top;
   logic        clk_sys_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic [7:0]  a = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [7:0]  wd = 8'h00;
   logic [2:0]  raise = 3'h0;
   logic [7:0]  rdata, v;
   logic [2:0]  req, ack_n, ack1;
   logic [19:0] maddr, addr1;
   logic        mrd, mwr, iord, iowr, aen, tc;
   logic [7:0]  mtab [3] = '{8'h69, 8'h06, 8'h83};
   int          fails = 0;
   int          compares = 0;
   int          n_rd, n_iow, n_tc, n_aen;
   ////////////////////////////////////////////////////////////////////////////
   // Clock, design and adapter
   always #2.5 clk_sys_i = ~clk_sys_i;
   dma_three_channel uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(a), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdata), .transfer_req_i(req), .transfer_ack_n_o(ack_n),
      .mem_addr_o(maddr), .mem_read_o(mrd), .mem_write_o(mwr), .chan_io_read_o(iord),
      .chan_io_write_o(iowr), .addr_enable_o(aen), .terminal_count_o(tc));
   io_adapter_model adapter (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .raise_i(raise),
      .transfer_ack_n_i(ack_n), .transfer_req_o(req));
   ////////////////////////////////////////////////////////////////////////////
   // Register port tasks: one strobe cycle, driven at the falling edge
   task automatic wr_reg(input logic [7:0] ad, input logic [7:0] d);
      @(negedge clk_sys_i);
      a = ad;
      wd = d;
      wr = 1'b1;
      @(negedge clk_sys_i);
      wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] ad, output logic [7:0] d);
      @(negedge clk_sys_i);
      a = ad;
      rd = 1'b1;
      @(negedge clk_sys_i);
      rd = 1'b0;
      d = rdata;
   endtask
   task automatic diag(input logic [7:0] p, output logic [7:0] d);
      wr_reg(8'h00, p);
      rd_reg(8'h01, d);
   endtask
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk20(input string nm, input logic [19:0] e, input logic [19:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic report_and_stop;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Watchdog: a hang counts as a mismatch
   initial begin
      #100us;
      fails++;
      report_and_stop();
   end
   // Main sequence
   initial begin
      repeat (5) @(negedge clk_sys_i);
      reset_n_i = 1'b1;
      rd_reg(8'h08, v);
      chk8("status", 8'h00, v);
      diag(8'h07, v);
      chk8("command", dma_regs_pkg::CMD_RESET, v);
      wr_reg(8'h08, 8'hFF);
      diag(8'h07, v);
      chk8("command", 8'h44, v);
      wr_reg(8'h0F, 8'h0A);
      diag(8'h03, v);
      chk8("masks", 8'h0A, v);
      wr_reg(8'h0A, 8'h03);
      diag(8'h03, v);
      chk8("masks", 8'h02, v);
      wr_reg(8'h0E, 8'h5A);
      diag(8'h03, v);
      chk8("masks", 8'h00, v);
      wr_reg(8'h0D, 8'h00);
      diag(8'h03, v);
      chk8("masks", 8'h0E, v);
      diag(8'h07, v);
      chk8("command", 8'h40, v);
      // Soft request while disabled: visible, never granted
      wr_reg(8'h09, 8'h06);
      diag(8'h0B, v);
      chk8("soft request", 8'h04, v);
      rd_reg(8'h08, v);
      chk8("status", 8'h40, v);
      chk8("ack", 8'h07, {5'h00, ack_n});
      wr_reg(8'h09, 8'h02);
      // Every transfer mode code, one per channel, read back per channel
      for (int k = 0; k < 3; k++) begin
         wr_reg(8'h0B, mtab[k]);
      end
      for (int k = 0; k < 3; k++) begin
         diag(8'h08 + 8'(k), v);
         chk8("mode", mtab[k] & 8'hFC, v & 8'hFC);
      end
      // Odd access then clear-pointer; a stuck pointer would misplace the count bytes
      wr_reg(8'h02, 8'h34);
      wr_reg(8'h02, 8'h12);
      wr_reg(8'h03, 8'h77);
      wr_reg(8'h0C, 8'h99);
      wr_reg(8'h03, 8'h01);
      wr_reg(8'h03, 8'h00);
      rd_reg(8'h02, v);
      chk8("address low", 8'h34, v);
      rd_reg(8'h02, v);
      chk8("address high", 8'h12, v);
      wr_reg(8'h07, 8'h00);
      wr_reg(8'h07, 8'h00);
      wr_reg(8'h83, 8'h05);
      wr_reg(8'h0B, 8'hA9);
      wr_reg(8'h0B, 8'h03);
      wr_reg(8'h0E, 8'h00);
      wr_reg(8'h08, 8'h04);
      // Channels 1 and 3 request together
      @(negedge clk_sys_i);
      raise = 3'b101;
      @(negedge clk_sys_i);
      raise = 3'b000;
      ack1 = 3'h7;
      n_rd = 0;
      n_iow = 0;
      n_tc = 0;
      n_aen = 0;
      repeat (80) begin
         @(negedge clk_sys_i);
         if (ack1 === 3'h7 && ack_n !== 3'h7) begin
            ack1 = ack_n;
            addr1 = maddr;
         end
         n_rd += int'(mrd === 1'b1 && mwr === 1'b0 && iord === 1'b0);
         n_iow += int'(iowr === 1'b1);
         n_tc += int'(tc === 1'b1);
         n_aen += int'(aen === 1'b1);
      end
      chk8("first ack", {5'h00, ack1}, 8'h06);
      chk20("memory address", 20'h51234, addr1);
      chk20("read cycles", 20'd6, 20'(n_rd));
      chk20("io write cycles", 20'd6, 20'(n_iow));
      chk20("tc pulses", 20'd2, 20'(n_tc));
      // Two block bytes on channel 1 plus one verify byte on channel 3 own the channel
      chk20("address enable cycles", 20'd15, 20'(n_aen));
      wr_reg(8'h0C, 8'h00);
      rd_reg(8'h02, v);
      chk8("address low", 8'h36, v);
      rd_reg(8'h03, v);
      chk8("count high", 8'hFF, v);
      rd_reg(8'h08, v);
      chk8("status", 8'h0A, v);
      rd_reg(8'h08, v);
      chk8("status", 8'h00, v);
      // Software request on channel 2: demand mode, address down, I/O into memory
      wr_reg(8'h04, 8'h00);
      wr_reg(8'h04, 8'h20);
      wr_reg(8'h05, 8'h01);
      wr_reg(8'h05, 8'h00);
      wr_reg(8'h09, 8'h06);
      n_rd = 0;
      n_iow = 0;
      n_tc = 0;
      repeat (40) begin
         @(negedge clk_sys_i);
         n_rd += int'(mwr === 1'b1 && mrd === 1'b0 && iowr === 1'b0);
         n_iow += int'(iord === 1'b1);
         n_tc += int'(tc === 1'b1);
      end
      chk20("memory write cycles", 20'd6, 20'(n_rd));
      chk20("io read cycles", 20'd6, 20'(n_iow));
      chk20("tc pulses", 20'd1, 20'(n_tc));
      wr_reg(8'h0C, 8'h00);
      rd_reg(8'h04, v);
      chk8("address low", 8'hFE, v);
      rd_reg(8'h04, v);
      chk8("address high", 8'h1F, v);
      diag(8'h0B, v);
      chk8("soft request", 8'h00, v);
      rd_reg(8'h08, v);
      chk8("status", 8'h04, v);
      report_and_stop();
   end
endmodule
`default_nettype wire

// File: tb/io_adapter_model.sv
// Expansion-channel adapter model that raises transfer requests
`timescale 1ns/10ps
`default_nettype none
module io_adapter_model (
   input  wire logic       clk_sys_i,
   input  wire logic       reset_n_i,
   input  wire logic [2:0] raise_i,
   input  wire logic [2:0] transfer_ack_n_i,
   output logic      [2:0] transfer_req_o
);
   // Request held until its acknowledge goes low; dropping it earlier could lose the grant
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         transfer_req_o <= 3'h0;
      end else begin
         transfer_req_o <= (transfer_req_o | raise_i) & transfer_ack_n_i;
      end
   end
endmodule
`default_nettype wire

// File: verilog/dma_regs_pkg.sv
// Register map, field positions, reset values and timing for the three-channel DMA controller
`default_nettype none
package dma_regs_pkg;
   // Register port offsets
   localparam logic [7:0] OFS_POINTER    = 8'h00;
   localparam logic [7:0] OFS_DIAG_DATA  = 8'h01;
   localparam logic [7:0] OFS_CH1_ADDR   = 8'h02;
   localparam logic [7:0] OFS_CH3_COUNT  = 8'h07;
   localparam logic [7:0] OFS_CMD_STAT   = 8'h08;
   localparam logic [7:0] OFS_SOFT_REQ   = 8'h09;
   localparam logic [7:0] OFS_ONE_MASK   = 8'h0A;
   localparam logic [7:0] OFS_MODE       = 8'h0B;
   localparam logic [7:0] OFS_CLR_BYTEFF = 8'h0C;
   localparam logic [7:0] OFS_MCLEAR     = 8'h0D;
   localparam logic [7:0] OFS_CLR_MASKS  = 8'h0E;
   localparam logic [7:0] OFS_ALL_MASKS  = 8'h0F;
   localparam logic [7:0] OFS_FACTORY    = 8'h80;
   localparam logic [7:0] OFS_CH2_PAGE   = 8'h81;
   localparam logic [7:0] OFS_CH3_PAGE   = 8'h82;
   localparam logic [7:0] OFS_CH1_PAGE   = 8'h83;
   // Diagnostic pointer codes
   localparam logic [7:0] PTR_MASKS      = 8'h03;
   localparam logic [7:0] PTR_CMD        = 8'h07;
   localparam logic [7:0] PTR_CH1_MODE   = 8'h08;
   localparam logic [7:0] PTR_SOFT_REQ   = 8'h0B;
   // Field positions
   localparam int CMD_ACK_POL_BIT  = 7;
   localparam int CMD_REQ_POL_BIT  = 6;
   localparam int CMD_ENABLE_BIT   = 2;
   localparam int SET_BIT          = 2;
   localparam int MODE_INC_BIT     = 5;
   // Transfer modes (mode bits 7-6) and directions (mode bits 3-2)
   localparam logic [1:0] XMODE_DEMAND = 2'h0;
   localparam logic [1:0] XMODE_BLOCK  = 2'h2;
   localparam logic [1:0] DIR_WRITE    = 2'h1;
   localparam logic [1:0] DIR_READ     = 2'h2;
   // Values after reset or master clear
   localparam logic [7:0]  CMD_RESET   = 8'h40;
   localparam logic [2:0]  MASK_RESET  = 3'h7;
   localparam logic [7:0]  MODE_RESET  = 8'h00;
   localparam logic [15:0] WORD_RESET  = 16'h0000;
   localparam logic [3:0]  PAGE_RESET  = 4'h0;
   // Controller clock cycles per transferred byte
   localparam int BYTE_CYCLES = 5;
endpackage
`default_nettype wire

// File: verilog/dma_three_channel.sv
// Three-channel DMA controller: byte-wide register ports, request arbitration and byte transfer sequencer
//
// Operation
// - Command bit 7 stays 0, bit 6 stays 1; bit 2 enables the controller.
// - Command register reads back through diagnostic data when the pointer holds 07.
// - Status shows requests of channels 3..1 in bits 7..5, terminal counts in 3..1.
// - Request port sets or clears a software request for the channel in bits 1-0.
// - Single-mask port sets or clears one channel mask; masks read back at pointer 03.
// - Mode bits 7-6 pick demand, single or block transfers.
// - Mode bit 5 makes the address count up, otherwise down, per byte.
// - Mode bits 3-2 pick verify, write to memory or read from memory.
// - Mode bits 1-0 pick the channel; modes read back at pointers 08, 09, 0A.
// - Byte flip-flop steers 16-bit accesses low then high, toggling each access.
// - Reset, master clear or clear-pointer write clears the byte flip-flop.
// - Master clear returns all registers to defaults and masks every channel.
// - Clear-mask write unmasks all channels regardless of data.
// - All-mask port loads masks 3..1 from bits 3..1; reads back at pointer 03.
// - Port 000 selects an internal register; port 001 reads or writes it.
// - Each channel has 16-bit address and count registers from port 002 on.
// - A 4-bit page per channel forms the upper bits of a 20-bit address.
// - Each transferred byte takes five controller clock cycles.
// - Simultaneous requests are granted channel 1 first, channel 3 last.
`timescale 1ns/10ps
`default_nettype none
module dma_three_channel (
   input  wire logic        clk_sys_i,
   input  wire logic        reset_n_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [7:0]  reg_wdata_i,
   output logic      [7:0]  reg_rdata_o,
   input  wire logic [2:0]  transfer_req_i,
   output logic      [2:0]  transfer_ack_n_o,
   output logic      [19:0] mem_addr_o,
   output logic             mem_read_o,
   output logic             mem_write_o,
   output logic             chan_io_read_o,
   output logic             chan_io_write_o,
   output logic             addr_enable_o,
   output logic             terminal_count_o
);

   typedef enum logic {ST_IDLE, ST_XFER} xfer_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // State
   logic [2:0]  req_meta;
   logic [2:0]  req_sync;
   logic [7:0]  diag_pointer;
   logic [7:0]  cmd_reg;
   logic [2:0]  mask;
   logic [2:0]  soft_req;
   logic [2:0]  tc_flag;
   logic        byte_ff;
   logic [15:0] cur_addr  [0:2];
   logic [15:0] cur_count [0:2];
   logic [7:0]  mode_reg  [0:2];
   logic [3:0]  page_reg  [0:2];
   xfer_state_t state;
   logic [2:0]  phase;
   logic [1:0]  act_ch;

   ////////////////////////////////////////////////////////////////////////////
   // Register port decode
   wire        wr_ptr    = reg_wr_i && (reg_addr_i == dma_regs_pkg::OFS_POINTER);
   wire        wr_diag   = reg_wr_i && (reg_addr_i == dma_regs_pkg::OFS_DIAG_DATA);
   wire        wr_cmd    = reg_wr_i && (reg_addr_i == dma_regs_pkg::OFS_CMD_STAT);
   wire        rd_status = reg_rd_i && (reg_addr_i == dma_regs_pkg::OFS_CMD_STAT);
   wire        wr_req    = reg_wr_i && (reg_addr_i == dma_regs_pkg::OFS_SOFT_REQ);
   wire        wr_one    = reg_wr_i && (reg_addr_i == dma_regs_pkg::OFS_ONE_MASK);
   wire        wr_mode   = reg_wr_i && (reg_addr_i == dma_regs_pkg::OFS_MODE);
   wire        clr_ff    = reg_wr_i && (reg_addr_i == dma_regs_pkg::OFS_CLR_BYTEFF);
   wire        mclr      = reg_wr_i && (reg_addr_i == dma_regs_pkg::OFS_MCLEAR);
   wire        wr_unmask = reg_wr_i && (reg_addr_i == dma_regs_pkg::OFS_CLR_MASKS);
   wire        wr_all    = reg_wr_i && (reg_addr_i == dma_regs_pkg::OFS_ALL_MASKS);
   wire        in_chan   = (reg_addr_i >= dma_regs_pkg::OFS_CH1_ADDR) &&
                           (reg_addr_i <= dma_regs_pkg::OFS_CH3_COUNT);
   wire        acc16     = (reg_wr_i || reg_rd_i) && in_chan;
   wire [1:0]  sel_ch    = reg_wdata_i[1:0];
   wire        set_bit   = reg_wdata_i[dma_regs_pkg::SET_BIT];

   // Writes through the diagnostic data port land on the register the pointer names
   wire        diag_cmd   = wr_diag && (diag_pointer == dma_regs_pkg::PTR_CMD);
   wire        diag_masks = wr_diag && (diag_pointer == dma_regs_pkg::PTR_MASKS);
   wire        diag_req   = wr_diag && (diag_pointer == dma_regs_pkg::PTR_SOFT_REQ);
   wire        cmd_we     = wr_cmd || diag_cmd;
   wire        cmd_en     = cmd_reg[dma_regs_pkg::CMD_ENABLE_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Arbitration: hardware requests are masked, software requests are not
   wire [2:0]  pending   = (req_sync & ~mask) | soft_req;
   wire        start     = (state == ST_IDLE) && cmd_en && (pending != 3'h0);
   wire [1:0]  grant_ch  = pending[0] ? 2'h0 : (pending[1] ? 2'h1 : 2'h2);
   wire        byte_done = (state == ST_XFER) && (phase == 3'(dma_regs_pkg::BYTE_CYCLES - 1));
   wire        tc_now    = byte_done && (cur_count[act_ch] == 16'h0000);
   wire [7:0]  act_mode  = mode_reg[act_ch];
   wire        keep_on   = !tc_now && cmd_en &&
                           ((act_mode[7:6] == dma_regs_pkg::XMODE_BLOCK) ||
                            ((act_mode[7:6] == dma_regs_pkg::XMODE_DEMAND) && req_sync[act_ch]));
   wire        strobe    = (state == ST_XFER) && (phase != 3'h0) && !byte_done;
   wire [1:0]  dir       = act_mode[3:2];

   ////////////////////////////////////////////////////////////////////////////
   // Read data selection
   wire [7:0]  status_val = {pending[2], pending[1], pending[0], 1'b0,
                             tc_flag[2], tc_flag[1], tc_flag[0], 1'b0};
   wire [1:0]  rd_ch      = 2'((reg_addr_i - dma_regs_pkg::OFS_CH1_ADDR) >> 1);
   wire [15:0] rd_word    = reg_addr_i[0] ? cur_count[rd_ch] : cur_addr[rd_ch];
   wire [7:0]  rd_half    = byte_ff ? rd_word[15:8] : rd_word[7:0];
   wire [1:0]  ptr_mode   = 2'(diag_pointer - dma_regs_pkg::PTR_CH1_MODE);
   wire        ptr_is_mode = (diag_pointer >= dma_regs_pkg::PTR_CH1_MODE) &&
                             (diag_pointer < dma_regs_pkg::PTR_SOFT_REQ);
   wire [7:0]  diag_val   = (diag_pointer == dma_regs_pkg::PTR_CMD)      ? cmd_reg :
                            (diag_pointer == dma_regs_pkg::PTR_MASKS)    ? {4'h0, mask, 1'b0} :
                            (diag_pointer == dma_regs_pkg::PTR_SOFT_REQ) ? {4'h0, soft_req, 1'b0} :
                            ptr_is_mode                                  ? mode_reg[ptr_mode] :
                            8'h00;
   wire [7:0]  read_mux   = (reg_addr_i == dma_regs_pkg::OFS_POINTER)   ? diag_pointer :
                            (reg_addr_i == dma_regs_pkg::OFS_DIAG_DATA) ? diag_val :
                            in_chan                                     ? rd_half :
                            (reg_addr_i == dma_regs_pkg::OFS_CMD_STAT)  ? status_val :
                            8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Request pins come from another clock domain, so two flip-flops first
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         req_meta <= 3'h0;
         req_sync <= 3'h0;
      end else begin
         req_meta <= transfer_req_i;
         req_sync <= req_meta;
      end
   end

   // Pointer, command and byte flip-flop; polarity bits are fixed so software cannot break the pins
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         diag_pointer <= 8'h00;
         cmd_reg      <= dma_regs_pkg::CMD_RESET;
         byte_ff      <= 1'b0;
      end else if (mclr) begin
         diag_pointer <= 8'h00;
         cmd_reg      <= dma_regs_pkg::CMD_RESET;
         byte_ff      <= 1'b0;
      end else begin
         if (wr_ptr)
            diag_pointer <= reg_wdata_i;
         if (cmd_we)
            cmd_reg <= {1'b0, 1'b1, 3'h0, reg_wdata_i[dma_regs_pkg::CMD_ENABLE_BIT], 2'h0};
         if (clr_ff)
            byte_ff <= 1'b0;
         else if (acc16)
            byte_ff <= ~byte_ff;
      end
   end

   // Masks: clear-all first, then load-all, then per-channel forms
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i)
         mask <= dma_regs_pkg::MASK_RESET;
      else if (mclr)
         mask <= dma_regs_pkg::MASK_RESET;
      else if (wr_unmask)
         mask <= 3'h0;
      else if (wr_all || diag_masks)
         mask <= reg_wdata_i[3:1];
      else if (wr_one && (sel_ch != 2'h0))
         mask[sel_ch - 2'h1] <= set_bit;
   end

   // Software requests end at terminal count; a write in the same cycle wins and that clear is skipped
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i)
         soft_req <= 3'h0;
      else if (mclr)
         soft_req <= 3'h0;
      else if (diag_req)
         soft_req <= reg_wdata_i[3:1];
      else if (wr_req && (sel_ch != 2'h0))
         soft_req[sel_ch - 2'h1] <= set_bit;
      else if (tc_now)
         soft_req[act_ch] <= 1'b0;
   end

   // Terminal count flags: a new count beats a status read in the same cycle
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i)
         tc_flag <= 3'h0;
      else if (mclr)
         tc_flag <= 3'h0;
      else if (tc_now)
         tc_flag <= (rd_status ? 3'h0 : tc_flag) | (3'h1 << act_ch);
      else if (rd_status)
         tc_flag <= 3'h0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-channel address, count, mode and page; a CPU write wins over a byte update
   for (genvar i = 0; i < 3; i++) begin : g_chan
      localparam logic [7:0] A_OFS = dma_regs_pkg::OFS_CH1_ADDR + 8'(2 * i);
      localparam logic [7:0] P_OFS = (i == 0) ? dma_regs_pkg::OFS_CH1_PAGE :
                                     (i == 1) ? dma_regs_pkg::OFS_CH2_PAGE : dma_regs_pkg::OFS_CH3_PAGE;
      wire addr_we = reg_wr_i && (reg_addr_i == A_OFS);
      wire cnt_we  = reg_wr_i && (reg_addr_i == A_OFS + 8'h01);
      wire mode_we = (wr_mode && (sel_ch == 2'(i + 1))) ||
                     (wr_diag && (diag_pointer == dma_regs_pkg::PTR_CH1_MODE + 8'(i)));
      wire page_we = reg_wr_i && (reg_addr_i == P_OFS);
      wire upd     = byte_done && (act_ch == 2'(i));
      wire up      = mode_reg[i][dma_regs_pkg::MODE_INC_BIT];

      always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            cur_addr[i]  <= dma_regs_pkg::WORD_RESET;
            cur_count[i] <= dma_regs_pkg::WORD_RESET;
            mode_reg[i]  <= dma_regs_pkg::MODE_RESET;
            page_reg[i]  <= dma_regs_pkg::PAGE_RESET;
         end else if (mclr) begin
            cur_addr[i]  <= dma_regs_pkg::WORD_RESET;
            cur_count[i] <= dma_regs_pkg::WORD_RESET;
            mode_reg[i]  <= dma_regs_pkg::MODE_RESET;
            page_reg[i]  <= dma_regs_pkg::PAGE_RESET;
         end else begin
            if (addr_we && byte_ff)
               cur_addr[i][15:8] <= reg_wdata_i;
            else if (addr_we)
               cur_addr[i][7:0] <= reg_wdata_i;
            else if (upd)
               cur_addr[i] <= up ? cur_addr[i] + 16'h0001 : cur_addr[i] - 16'h0001;
            if (cnt_we && byte_ff)
               cur_count[i][15:8] <= reg_wdata_i;
            else if (cnt_we)
               cur_count[i][7:0] <= reg_wdata_i;
            else if (upd)
               cur_count[i] <= cur_count[i] - 16'h0001;
            if (mode_we)
               mode_reg[i] <= reg_wdata_i;
            if (page_we)
               page_reg[i] <= reg_wdata_i[3:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Byte sequencer: phase 0 address out, 1-3 strobes, 4 update and decide
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state  <= ST_IDLE;
         phase  <= 3'h0;
         act_ch <= 2'h0;
      end else if (mclr) begin
         state  <= ST_IDLE;
         phase  <= 3'h0;
      end else if (start) begin
         state  <= ST_XFER;
         phase  <= 3'h0;
         act_ch <= grant_ch;
      end else if (byte_done) begin
         phase  <= 3'h0;
         state  <= keep_on ? ST_XFER : ST_IDLE;
      end else if (state == ST_XFER) begin
         phase  <= phase + 3'h1;
      end
   end

   // Registered pins; the extra cycle of lag keeps every output glitch-free
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         transfer_ack_n_o <= 3'h7;
         mem_addr_o       <= 20'h00000;
         mem_read_o       <= 1'b0;
         mem_write_o      <= 1'b0;
         chan_io_read_o   <= 1'b0;
         chan_io_write_o  <= 1'b0;
         addr_enable_o    <= 1'b0;
         terminal_count_o <= 1'b0;
      end else begin
         transfer_ack_n_o <= (state == ST_XFER) ? ~(3'h1 << act_ch) : 3'h7;
         mem_addr_o       <= {page_reg[act_ch], cur_addr[act_ch]};
         mem_read_o       <= strobe && (dir == dma_regs_pkg::DIR_READ);
         chan_io_write_o  <= strobe && (dir == dma_regs_pkg::DIR_READ);
         chan_io_read_o   <= strobe && (dir == dma_regs_pkg::DIR_WRITE);
         mem_write_o      <= strobe && (dir == dma_regs_pkg::DIR_WRITE);
         addr_enable_o    <= (state == ST_XFER);
         terminal_count_o <= tc_now;
      end
   end

   // Read data is captured on the read strobe and held until the next read
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i)
         reg_rdata_o <= 8'h00;
      else if (reg_rd_i)
         reg_rdata_o <= read_mux;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_byte_body;
      ((state == ST_XFER) && !byte_done) [*4] ##1 byte_done;
   endsequence

   sequence s_mclear_done;
      (mask == dma_regs_pkg::MASK_RESET) && (cmd_reg == dma_regs_pkg::CMD_RESET) && !byte_ff;
   endsequence

   a_cmd_polarity: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      !cmd_reg[dma_regs_pkg::CMD_ACK_POL_BIT] && cmd_reg[dma_regs_pkg::CMD_REQ_POL_BIT])
      else $error("command polarity bits changed");
   a_diag_cmd_read: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (reg_rd_i && reg_addr_i == dma_regs_pkg::OFS_DIAG_DATA && diag_pointer == dma_regs_pkg::PTR_CMD)
      |=> reg_rdata_o == $past(cmd_reg))
      else $error("command not seen through diagnostic port");
   a_status_layout: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      rd_status |=> (reg_rdata_o[3:1] == $past(tc_flag)) && !reg_rdata_o[4] && !reg_rdata_o[0])
      else $error("status layout wrong");
   a_soft_req_set: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_req && reg_wdata_i[2:0] == 3'h5) |=> soft_req[0])
      else $error("software request not set");
   a_clear_masks: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      wr_unmask |=> mask == 3'h0)
      else $error("masks not cleared");
   a_master_clear: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      mclr |=> s_mclear_done)
      else $error("master clear incomplete");
   a_byte_ff_toggle: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (acc16 && !mclr) |=> byte_ff != $past(byte_ff))
      else $error("byte flip-flop did not toggle");
   a_byte_five_cycles: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (start && !mclr) |=> s_byte_body)
      else $error("byte did not take five cycles");
   a_priority_grant: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (start && !mclr && pending[0]) |=> act_ch == 2'h0)
      else $error("channel 1 not granted first");
   a_disabled_idle: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (state == ST_IDLE && !cmd_en) |=> state == ST_IDLE)
      else $error("grant while disabled");
   a_tc_read_clear: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (rd_status && !tc_now && !mclr) |=> tc_flag == 3'h0)
      else $error("terminal count not cleared by status read");

endmodule
`default_nettype wire
